// File: scpr_port.sv
// serial control port: instruction decode, read/write sequencing, pins
// Contract
// - read shifts out N bytes, N 1 to 3
// - length code 3 streams until chip select rises; here streaming also stops after the last address
// - address steps once per byte, MSB-first wrapping from 0 to 0x232
// - read bit changes on serial clock falling edge
// - reset gives bidirectional pin, driven only reading
// - config bits 7 and 0 select output pin
// - control bit selects buffer or active readback
// - instruction: direction, length, 13-bit address
// - length codes one, two, three, streaming
// - reset gives MSB-first order
// - config bits 1 and 6 give LSB-first now
// - MSB-first decrements address per byte
// - LSB-first increments address per byte
// - streaming stops after last address accessed
// - memory transfer blocks all but status read
// - status bit shows memory transfer busy
// - two-wire acknowledge only when transfer done
// - status pin can show memory transfer
// - write bits captured on rising edge
// - chip select high leaves outputs undriven
// - off-boundary chip select rise abandons transfer
// - update bit copies buffered writes at once
`timescale 1ns/1ps

module scpr_port import scpr_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // serial pins
  input wire logic SCLK,
  input wire logic CS_B,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE,
  output logic SDO_O,
  output logic SDO_OE,
  // register bank
  output scpr_req_t REG_REQ,
  input wire logic [7:0] REG_RDATA,
  output logic REG_RD_ACTIVE,
  output logic UPDATE,
  // memory transfer status
  input wire logic EE_BUSY,
  input wire logic STATUS_SEL,
  input wire logic STATUS_ALT,
  output logic STATUS_PIN,
  output logic I2C_ACK_OK
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    scpr_st_t st;
    logic [3:0] cnt;
    logic [15:0] sh;
    logic instr_done;
    logic rnw;
    logic [1:0] len;
    logic [1:0] left;
    logic [12:0] addr;
    logic [7:0] cfg;
    logic rbsel;
    logic [7:0] rbyte;
    logic [7:0] dout;
    logic out_bit;
    logic sdio_oe;
    logic sdo_oe;
    scpr_req_t req;
    logic upd;
    logic status;
    logic ack;
    logic sclk_d;
    logic cs_d;
  } scpr_port_t;

  scpr_port_t q;
  scpr_port_t d;
  logic sclk_f;
  logic cs_b_f;
  logic sdio_f;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic lsb;
  logic uni;
  logic [15:0] w;
  logic [7:0] b;
  logic [12:0] nxt;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  scpr_sync #(.RST_VAL(1'h0)) u_sclk (.CLK(CLK), .RST_B(RST_B), .d(SCLK), .q(sclk_f));
  scpr_sync #(.RST_VAL(1'h1)) u_cs (.CLK(CLK), .RST_B(RST_B), .d(CS_B), .q(cs_b_f));
  scpr_sync #(.RST_VAL(1'h0)) u_sdio (.CLK(CLK), .RST_B(RST_B), .d(SDIO_I), .q(sdio_f));

  assign rise = sclk_f & ~q.sclk_d;
  assign fall = ~sclk_f & q.sclk_d;
  assign cs_fall = ~cs_b_f & q.cs_d;
  assign cs_rise = cs_b_f & ~q.cs_d;
  assign lsb = q.cfg[CFG_LSB_HI] & q.cfg[CFG_LSB_LO];
  assign uni = q.cfg[CFG_UNI_HI] & q.cfg[CFG_UNI_LO];
  assign w = lsb ? {sdio_f, q.sh[15:1]} : {q.sh[14:0], sdio_f};
  assign b = w[7:0];

  always_comb begin
    if (lsb) begin
      nxt = q.addr + 13'h0001;
    end else if (q.addr == 13'h0000) begin
      nxt = ADDR_LAST;
    end else begin
      nxt = q.addr - 13'h0001;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.req.we = 1'h0;
    d.req.re = 1'h0;
    d.upd = 1'h0;
    d.sclk_d = sclk_f;
    d.cs_d = cs_b_f;
    d.status = STATUS_SEL ? EE_BUSY : STATUS_ALT;
    d.ack = ~EE_BUSY;
    // readback fetch, one cycle after the request
    if (q.req.re) begin
      if (EE_BUSY && q.req.addr != ADDR_EESTAT) begin
        d.rbyte = 8'h00;
      end else if (q.req.addr == ADDR_EESTAT) begin
        d.rbyte = {7'h00, EE_BUSY};
      end else if (q.req.addr[9:0] == ADDR_CFG[9:0]) begin
        d.rbyte = q.cfg;
      end else if (q.req.addr[9:0] == ADDR_RBSEL[9:0]) begin
        d.rbyte = {7'h00, q.rbsel};
      end else if (q.req.addr[9:0] == ADDR_UPD[9:0]) begin
        d.rbyte = 8'h00;
      end else begin
        d.rbyte = REG_RDATA;
      end
    end
    if (cs_fall) begin
      if (q.st == ST_WAIT) begin
        d.st = q.instr_done ? ST_DATA : ST_INSTR;
      end else begin
        d.st = ST_INSTR;
        d.cnt = 4'h0;
        d.instr_done = 1'h0;
      end
    end else if (cs_rise) begin
      if (q.cnt[2:0] != 3'h0 || q.st == ST_IDLE) begin
        d.st = ST_IDLE;
        d.cnt = 4'h0;
      end else if (q.st == ST_DATA && q.len == LEN_STREAM) begin
        d.st = ST_IDLE;
      end else begin
        d.st = ST_WAIT;
      end
    end else if (rise && !cs_b_f) begin
      case (q.st)
        ST_INSTR: begin
          d.sh = w;
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == INSTR_LAST) begin
            d.rnw = w[15];
            d.len = w[14:13];
            // upper bits kept, status address 0x0B00 uses them
            d.addr = w[12:0];
            d.left = w[14:13];
            d.cnt = 4'h0;
            d.instr_done = 1'h1;
            d.st = ST_DATA;
            d.req.addr = w[12:0];
            d.req.re = w[15];
          end
        end
        ST_DATA: begin
          d.sh = w;
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == BYTE_LAST) begin
            d.cnt = 4'h0;
            if (!q.rnw && !EE_BUSY) begin
              if (q.addr[9:0] == ADDR_CFG[9:0]) begin
                d.cfg = b;
              end else if (q.addr[9:0] == ADDR_RBSEL[9:0]) begin
                d.rbsel = b[RBSEL_BIT];
              end else if (q.addr[9:0] == ADDR_UPD[9:0]) begin
                d.upd = b[UPD_BIT];
              end else begin
                d.req.we = 1'h1;
                d.req.addr = q.addr;
                d.req.data = b;
              end
            end
            d.addr = nxt;
            if (q.len == LEN_STREAM) begin
              if (q.addr == ADDR_LAST) begin
                d.st = ST_IDLE;
              end
            end else if (q.left == 2'h0) begin
              d.st = ST_IDLE;
            end else begin
              d.left = q.left - 2'h1;
            end
            if (q.rnw) begin
              d.req.re = 1'h1;
              d.req.addr = nxt;
            end
          end
        end
        default: begin
          d.cnt = q.cnt;
        end
      endcase
    end
    // read bit changes on falling edge
    if (fall && !cs_b_f && q.st == ST_DATA && q.rnw) begin
      if (q.cnt[2:0] == 3'h0) begin
        d.out_bit = lsb ? q.rbyte[0] : q.rbyte[7];
        d.dout = lsb ? {1'h0, q.rbyte[7:1]} : {q.rbyte[6:0], 1'h0};
      end else begin
        d.out_bit = lsb ? q.dout[0] : q.dout[7];
        d.dout = lsb ? {1'h0, q.dout[7:1]} : {q.dout[6:0], 1'h0};
      end
    end
    // drive only in read data phase
    d.sdio_oe = !cs_b_f && d.st == ST_DATA && d.rnw && !uni;
    d.sdo_oe = !cs_b_f && d.st == ST_DATA && d.rnw && uni;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cfg <= CFG_RST;
      q.rbsel <= RBSEL_RST;
      q.cs_d <= 1'h1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign SDIO_O = q.out_bit;
  assign SDO_O = q.out_bit;
  assign SDIO_OE = q.sdio_oe;
  assign SDO_OE = q.sdo_oe;
  assign REG_REQ = q.req;
  assign REG_RD_ACTIVE = q.rbsel;
  assign UPDATE = q.upd;
  assign STATUS_PIN = q.status;
  assign I2C_ACK_OK = q.ack;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  hiz_cs_high_a: assert property (cs_b_f |=> !SDIO_OE && !SDO_OE)
    else $error("output driven with chip select high");
  pin_select_a: assert property ((SDIO_OE |-> !uni) and (SDO_OE |-> uni))
    else $error("readback on wrong pin");
  wrong_oe_a: assert property (SDIO_OE |-> q.rnw && q.st == ST_DATA)
    else $error("data pin driven outside read");
  msb_step_a: assert property (rise && !cs_b_f && !cs_fall && !cs_rise && q.st == ST_DATA
    && q.cnt == BYTE_LAST && !lsb && q.addr != 13'h0000
    |=> q.addr == $past(q.addr) - 13'h0001)
    else $error("address not decremented");
  lsb_step_a: assert property (rise && !cs_b_f && !cs_fall && !cs_rise && q.st == ST_DATA
    && q.cnt == BYTE_LAST && lsb |=> q.addr == $past(q.addr) + 13'h0001)
    else $error("address not incremented");
  stream_stop_a: assert property (rise && !cs_b_f && !cs_fall && !cs_rise && q.st == ST_DATA
    && q.cnt == BYTE_LAST && q.len == LEN_STREAM && q.addr == ADDR_LAST
    |=> q.st == ST_IDLE)
    else $error("stream did not stop");
  busy_write_a: assert property (REG_REQ.we |-> !$past(EE_BUSY))
    else $error("write passed while busy");
  ack_busy_a: assert property (EE_BUSY |=> !I2C_ACK_OK)
    else $error("acknowledge while busy");
  status_pin_a: assert property (STATUS_SEL |=> STATUS_PIN == $past(EE_BUSY))
    else $error("status pin not busy");
  abort_a: assert property (cs_rise && !cs_fall && q.cnt[2:0] != 3'h0 |=> q.st == ST_IDLE)
    else $error("off-boundary rise not aborted");
  restart_a: assert property (cs_fall && q.st != ST_WAIT |=> q.st == ST_INSTR && q.cnt == 4'h0)
    else $error("chip select fall did not restart");
  read_req_a: assert property (rise && !cs_b_f && !cs_fall && !cs_rise && q.st == ST_INSTR
    && q.cnt == INSTR_LAST && w[15] |=> REG_REQ.re ##1 !REG_REQ.re)
    else $error("read fetch missing");
  wait_hiz_a: assert property (q.st == ST_WAIT |-> !SDIO_OE && !SDO_OE)
    else $error("output driven while stalled");
  idle_hiz_a: assert property (q.st == ST_IDLE |-> !SDIO_OE && !SDO_OE)
    else $error("output driven while idle");
  one_pin_a: assert property (!(SDIO_OE && SDO_OE))
    else $error("both output pins driven");
  update_pulse_a: assert property (UPDATE |=> !UPDATE)
    else $error("update pulse too long");
  busy_read_a: assert property (REG_REQ.re && EE_BUSY && REG_REQ.addr != ADDR_EESTAT
    |=> q.rbyte == 8'h00)
    else $error("read passed while busy");
  status_read_a: assert property (REG_REQ.re && REG_REQ.addr == ADDR_EESTAT
    |=> q.rbyte == {7'h00, $past(EE_BUSY)})
    else $error("status byte wrong");

  read_cov_c: cover property (q.st == ST_DATA && q.rnw ##1 SDIO_OE);
  uni_cov_c: cover property (SDO_OE);
  write_cov_c: cover property (REG_REQ.we);
  stream_cov_c: cover property (q.len == LEN_STREAM && q.st == ST_DATA ##1 q.st == ST_IDLE);
  stall_cov_c: cover property (q.st == ST_WAIT ##[1:1000] q.st == ST_DATA);
endmodule : scpr_port

// File: scpr_pkg.sv
// serial control port: shared constants, types and the input synchroniser
`timescale 1ns/1ps

package scpr_pkg;
  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  // ---------------------------------------------------------------
  // addresses and fields
  // ---------------------------------------------------------------
  localparam logic [12:0] ADDR_CFG = 13'h0000;
  localparam logic [12:0] ADDR_RBSEL = 13'h0004;
  localparam logic [12:0] ADDR_UPD = 13'h0232;
  localparam logic [12:0] ADDR_LAST = 13'h0232;
  localparam logic [12:0] ADDR_EESTAT = 13'h0B00;
  localparam int CFG_UNI_HI = 7;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_LSB_LO = 1;
  localparam int CFG_UNI_LO = 0;
  localparam int RBSEL_BIT = 0;
  localparam int UPD_BIT = 0;
  localparam logic [7:0] CFG_RST = 8'h18;
  localparam logic RBSEL_RST = 1'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_INSTR = 2'h1,
    ST_DATA = 2'h3,
    ST_WAIT = 2'h2
  } scpr_st_t;

  // register request toward the register bank
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
    logic we;
    logic re;
  } scpr_req_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
  } scpr_sync_t;
endpackage : scpr_pkg

module scpr_sync import scpr_pkg::*; #(
  parameter logic RST_VAL = 1'h0
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // pin in, filtered level out
  input wire logic d,
  output logic q
);
  scpr_sync_t r_q;
  scpr_sync_t r_d;

  always_comb begin
    r_d = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    if (r_q.s2 == r_q.s3) begin
      r_d.f = r_q.s3;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      r_q <= {4{RST_VAL}};
    end else begin
      r_q <= r_d;
    end
  end

  // level counts as soon as the second and third agree
  assign q = r_d.f;
endmodule : scpr_sync

// File: scpr_host.sv
// host serial controller model for the control port pins
`timescale 1ns/1ps

module scpr_host import scpr_pkg::*; (
  // clock
  input wire logic CLK,
  // pins toward the port
  output logic SCLK,
  output logic CS_B,
  output logic SDIO_I,
  // pins from the port
  input wire logic SDIO_O,
  input wire logic SDIO_OE,
  input wire logic SDO_O,
  input wire logic SDO_OE
);
  logic drv_q = 1'h1;
  logic dat_q = 1'h0;
  logic lsb_q = 1'h0;
  logic uni_q = 1'h0;
  // half of the 48 ns serial clock period
  localparam real HALF_NS = 24.0;

  initial begin
    SCLK = 1'h0;
    CS_B = 1'h1;
  end
  // released line shows the inverse of its last level
  assign SDIO_I = SDIO_OE ? SDIO_O : (drv_q ? dat_q : !dat_q);

  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLK);
  endtask : wait_clk

  // ---------------------------------------------------------------
  // one frame of nbits clocks: header, then data bytes
  // ---------------------------------------------------------------
  task automatic xfer(input logic [15:0] ins, input int nbits, input logic [31:0] wd,
    output logic [31:0] rd);
    int idx;
    logic b;
    rd = 32'h00000000;
    @(posedge CLK);
    // link pins move off the clock grid
    #0.5;
    CS_B = 1'h0;
    for (int i = 0; i < nbits; i++) begin
      idx = (i < 16) ? (lsb_q ? i : 15 - i) : 8 * ((i - 16) / 8) + (lsb_q ? i % 8 : 7 - i % 8);
      b = (i < 16) ? ins[idx] : wd[idx];
      // data moves on the falling clock
      SCLK = 1'h0;
      dat_q = b;
      drv_q = !(ins[15] && i >= 16);
      #(HALF_NS);
      // readback taken at the rising clock
      if (i >= 16) begin
        rd[idx] = (uni_q ? SDO_OE : SDIO_OE) ? (uni_q ? SDO_O : SDIO_O) : 1'bx;
      end
      SCLK = 1'h1;
      #(HALF_NS);
    end
    SCLK = 1'h0;
    #(HALF_NS);
    CS_B = 1'h1;
    drv_q = 1'h1;
    wait_clk(8);
  endtask : xfer
endmodule : scpr_host

// File: scpr_port_test.sv
// self-checking bench for the serial control port
`timescale 1ns/1ps

module scpr_port_test import scpr_pkg::*; ;
  logic clk = 1'h0;
  logic rst_b = 1'h1;
  logic ee_busy = 1'h0;
  logic status_sel = 1'h0;
  logic status_alt = 1'h0;
  logic sclk, cs_b, sdio_i, sdio_o, sdio_oe, sdo_o, sdo_oe;
  logic reg_rd_active, update, status_pin, i2c_ack_ok;
  logic [7:0] reg_rdata;
  logic [31:0] rd;
  logic [20:0] wr_last = 21'h000000;
  scpr_req_t reg_req;
  int n_errors = 0;
  int checked = 0;
  int wr_cnt = 0;
  int upd_cnt = 0;

  initial begin
    forever #2.5 clk = !clk;
  end

  scpr_port dut_u (.CLK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b), .SDIO_I(sdio_i),
    .SDIO_O(sdio_o), .SDIO_OE(sdio_oe), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .REG_REQ(reg_req),
    .REG_RDATA(reg_rdata), .REG_RD_ACTIVE(reg_rd_active), .UPDATE(update),
    .EE_BUSY(ee_busy), .STATUS_SEL(status_sel), .STATUS_ALT(status_alt),
    .STATUS_PIN(status_pin), .I2C_ACK_OK(i2c_ack_ok));

  scpr_host host_u (.CLK(clk), .SCLK(sclk), .CS_B(cs_b), .SDIO_I(sdio_i), .SDIO_O(sdio_o),
    .SDIO_OE(sdio_oe), .SDO_O(sdo_o), .SDO_OE(sdo_oe));

  // ---------------------------------------------------------------
  // register bank: each address reads back its low byte
  // ---------------------------------------------------------------
  assign reg_rdata = reg_req.addr[7:0];

  always @(posedge clk) begin
    if (reg_req.we === 1'h1) begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= {reg_req.addr, reg_req.data};
    end
    if (update === 1'h1) begin
      upd_cnt <= upd_cnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic xfer(input logic [15:0] ins, input int nb, input logic [31:0] wd);
    host_u.xfer(ins, 16 + 8 * nb, wd, rd);
  endtask : xfer

  task automatic finish_test();
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk);
    check("sdio_oe", sdio_oe, 0);
    check("sdo_oe", sdo_oe, 0);
    check("ack idle", i2c_ack_ok, 1);
    check("rd_active", reg_rd_active, 0);
    xfer(16'h8010, 1, 0);
    check("read1", rd[7:0], 8'h10);
    xfer(16'hC001, 3, 0);
    check("read3 msb", rd[23:0], 24'h001801);
    xfer(16'h0010, 1, 32'hC3);
    check("write", wr_last, 21'h010C3);
    host_u.xfer(16'h0011, 20, 32'hFF, rd);
    check("abort", wr_cnt, 1);
    xfer(16'h8012, 1, 0);
    check("after abort", rd[7:0], 8'h12);
    xfer(16'h0004, 1, 32'h01);
    check("rd_active", reg_rd_active, 1);
    xfer(16'h0232, 1, 32'h01);
    check("update", upd_cnt, 1);
    xfer(16'h0000, 1, 32'h81);
    host_u.uni_q = 1'h1;
    xfer(16'h8010, 1, 0);
    check("sdo read", rd[7:0], 8'h10);
    xfer(16'h0000, 1, 32'h42);
    host_u.uni_q = 1'h0;
    host_u.lsb_q = 1'h1;
    xfer(16'hE230, 4, 0);
    check("stream lsb", rd, 32'hXX003130);
    ee_busy <= 1'h1;
    status_sel <= 1'h1;
    repeat (3) @(posedge clk);
    check("status pin", status_pin, 1);
    check("ack busy", i2c_ack_ok, 0);
    xfer(16'h8010, 1, 0);
    check("busy read", rd[7:0], 8'h00);
    xfer(16'h8B00, 1, 0);
    check("busy flag", rd[7:0], 8'h01);
    xfer(16'h0010, 1, 32'h55);
    check("busy write", wr_cnt, 1);
    ee_busy <= 1'h0;
    xfer(16'h8B00, 1, 0);
    check("done flag", rd[7:0], 8'h00);
    check("ack done", i2c_ack_ok, 1);
    check("oe idle", {sdio_oe, sdo_oe}, 0);
    finish_test();
  end
endmodule : scpr_port_test
